// ===== wdtlk_pkg.sv
// Shared constants and types for the supervision counter and its controller
package wdtlk_pkg;
  localparam logic [11:0] WDTLK_ADDR_KEY = 12'hFF0;
  localparam logic [11:0] WDTLK_ADDR_UPPER = 12'hFF1;
  localparam logic [11:0] WDTLK_ADDR_MIDDLE = 12'hFF2;
  localparam logic [11:0] WDTLK_ADDR_LOWER = 12'hFF3;
  localparam logic [7:0] WDTLK_KEY_FIRST = 8'h55;
  localparam logic [7:0] WDTLK_KEY_SECOND = 8'hAA;
  localparam logic [7:0] WDTLK_RST_UPPER = 8'h00;
  localparam logic [7:0] WDTLK_RST_MIDDLE = 8'h04;
  localparam logic [7:0] WDTLK_RST_LOWER = 8'h00;
  localparam logic [23:0] WDTLK_CNT_ZERO = 24'h000000;
  localparam logic [23:0] WDTLK_CNT_MAX = 24'hFFFFFF;
  localparam logic [23:0] WDTLK_CNT_NO_REFRESH = 24'h000002;
  localparam int WDTLK_STAT_WDT_BIT = 5;
  localparam int WDTLK_STAT_STOP_BIT = 4;
  // Controller registers on AHB-Lite (byte addresses)
  localparam logic [7:0] WDTLK_HREG_CMD = 8'h00;
  localparam logic [7:0] WDTLK_HREG_WDATA = 8'h04;
  localparam logic [7:0] WDTLK_HREG_STATUS = 8'h08;
  localparam logic [7:0] WDTLK_HREG_RDATA = 8'h0C;
  localparam int WDTLK_CMD_GO_BIT = 0;
  localparam int WDTLK_CMD_WRITE_BIT = 1;
  localparam int WDTLK_CMD_REFRESH_BIT = 2;
  localparam int WDTLK_CMD_ADDR_LSB = 8;
  typedef enum logic [1:0] {
    WDTLK_LOCKED,
    WDTLK_KEY1,
    WDTLK_OPEN_UPPER,
    WDTLK_OPEN_MIDDLE
  } wdtlk_lock_t;
  typedef enum logic [1:0] {
    WDTLK_M_IDLE,
    WDTLK_M_REQ,
    WDTLK_M_WAIT
  } wdtlk_mst_t;
endpackage

// ===== wdtlk_if.sv
// Register port and event lines between core and supervision counter
`timescale 1ns/1ps
`default_nettype none
interface wdtlk_if;
  logic req;
  logic we;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic refresh;
  logic stop_mode;
  logic irq;
  logic sys_reset;
  logic stop_recover;
  modport device (
    input req, we, addr, wdata, refresh, stop_mode,
    output rdata, ack, irq, sys_reset, stop_recover
  );
  modport core (
    output req, we, addr, wdata, refresh, stop_mode,
    input rdata, ack, irq, sys_reset, stop_recover
  );
endinterface
`default_nettype wire

// ===== wdtlk_lock.sv
// Unlock sequencer guarding the reload byte registers
`timescale 1ns/1ps
`default_nettype none
module wdtlk_lock
  import wdtlk_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  output logic wr_upper,
  output logic wr_middle,
  output logic wr_lower
);
  typedef struct packed {
    wdtlk_lock_t st;
    logic arm;
  } wdtlk_lk_state_t;
  wdtlk_lk_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    wr_upper = 1'b0;
    wr_middle = 1'b0;
    wr_lower = 1'b0;
    if (wr) begin
      // Any write that does not continue the sequence relocks
      s_d.st = WDTLK_LOCKED;
      s_d.arm = 1'b0;
      if (s_q.arm) begin
        // Lower byte only as the very next write after middle
        wr_lower = addr == WDTLK_ADDR_LOWER;
      end else begin
        unique case (s_q.st)
          WDTLK_LOCKED: begin
            if (addr == WDTLK_ADDR_KEY && wdata == WDTLK_KEY_FIRST) begin
              s_d.st = WDTLK_KEY1;
            end
          end
          WDTLK_KEY1: begin
            if (addr == WDTLK_ADDR_KEY && wdata == WDTLK_KEY_SECOND) begin
              s_d.st = WDTLK_OPEN_UPPER;
            end else if (addr == WDTLK_ADDR_KEY &&
                         wdata == WDTLK_KEY_FIRST) begin
              s_d.st = WDTLK_KEY1;
            end
          end
          WDTLK_OPEN_UPPER: begin
            if (addr == WDTLK_ADDR_UPPER) begin
              wr_upper = 1'b1;
              s_d.st = WDTLK_OPEN_MIDDLE;
            end
          end
          WDTLK_OPEN_MIDDLE: begin
            if (addr == WDTLK_ADDR_MIDDLE) begin
              wr_middle = 1'b1;
              s_d.arm = 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{st: WDTLK_LOCKED, arm: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ===== wdtlk_device.sv
// Supervision counter: time-out response, status, reload lock, live reads
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Time-out when count reaches zero
// - Option selects interrupt or system reset
// - Interrupt mode: raise irq, set watchdog flag
// - After interrupt time-out, count from all-ones
// - Status read clears watchdog flag
// - Stop, interrupt mode: recover, irq, both flags
// - Reset mode: force system reset, set flag
// - Stop, reset mode: recover, set both flags
// - Keys 55 then AA unlock reloads
// - Key writes change no stored bits
// - Software writes upper, middle, lower in order
// - Stray write relocks; reload writes ignored
// - Load reload on enable and refresh
// - Key register shares address with status
// - Reload is upper, middle, lower bytes
// - Reload byte reads return live count
// - Software never programs reload below four
// - Counts continuously; no refresh at two
// - Always-on option starts counter at reset
module wdtlk_device
  import wdtlk_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic always_on_option,
  input wire logic timeout_response_option,
  wdtlk_if.device bus
);
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] middle;
    logic [7:0] lower;
    logic [23:0] count;
    logic enabled;
    logic started;
    logic flag_wdt;
    logic flag_stop;
    logic irq;
    logic sys_reset;
    logic stop_recover;
    logic ack;
    logic [7:0] rdata;
  } wdtlk_dev_state_t;
  wdtlk_dev_state_t s_q, s_d;

  localparam logic [23:0] CNT_STEP = 24'h000001;
  localparam logic [23:0] CNT_MIN_RELOAD = 24'h000004;
  localparam int RD_BITS = 8;
  localparam logic [23:0] RST_RELOAD =
    {WDTLK_RST_UPPER, WDTLK_RST_MIDDLE, WDTLK_RST_LOWER};

  // The reset reload must itself respect the software minimum
  if (RST_RELOAD < CNT_MIN_RELOAD) begin : g_bad_reload
    $error("reset reload value below the minimum");
  end

  // Both status flags must land inside the byte-wide read path
  if (WDTLK_STAT_WDT_BIT >= RD_BITS || WDTLK_STAT_STOP_BIT >= RD_BITS ||
      WDTLK_STAT_WDT_BIT == WDTLK_STAT_STOP_BIT) begin : g_bad_bits
    $error("status flag positions do not fit the read byte");
  end

  // A minimal reload must still leave room for a refresh
  if (WDTLK_CNT_NO_REFRESH >= CNT_MIN_RELOAD) begin : g_bad_floor
    $error("refresh floor not below the minimum reload");
  end

  // Live count byte returned at a reload register address
  function automatic logic [7:0] live_byte(input logic [23:0] cnt,
                                           input logic [11:0] a);
    logic [7:0] b;
    b = 8'h00;
    unique case (a)
      WDTLK_ADDR_UPPER: b = cnt[23:16];
      WDTLK_ADDR_MIDDLE: b = cnt[15:8];
      WDTLK_ADDR_LOWER: b = cnt[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // Status byte returned at the shared key address
  function automatic logic [7:0] status_byte(input logic wdt,
                                             input logic stp);
    logic [7:0] b;
    b = 8'h00;
    b[WDTLK_STAT_WDT_BIT] = wdt;
    b[WDTLK_STAT_STOP_BIT] = stp;
    return b;
  endfunction

  logic wr;
  logic rd;
  logic wr_upper;
  logic wr_middle;
  logic wr_lower;
  logic timeout;
  logic refresh_ok;
  logic irq_mode;
  logic [23:0] reload;

  assign wr = bus.req && bus.we;
  assign rd = bus.req && !bus.we;
  assign reload = {s_q.upper, s_q.middle, s_q.lower};
  assign timeout = s_q.enabled && s_q.count == WDTLK_CNT_ZERO;
  // Refresh is refused from the count of two downwards
  assign refresh_ok = s_q.count > WDTLK_CNT_NO_REFRESH;
  assign irq_mode = !timeout_response_option;

  wdtlk_lock u_wdtlk_lock (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr(wr),
    .addr(bus.addr),
    .wdata(bus.wdata),
    .wr_upper(wr_upper),
    .wr_middle(wr_middle),
    .wr_lower(wr_lower)
  );

  always_comb begin
    s_d = s_q;
    s_d.ack = bus.req;
    s_d.irq = 1'b0;
    s_d.sys_reset = 1'b0;
    s_d.stop_recover = 1'b0;
    // Always-on option caught one cycle after reset release
    if (!s_q.started) begin
      s_d.started = 1'b1;
      if (always_on_option) begin
        s_d.enabled = 1'b1;
        s_d.count = reload;
      end
    end
    if (s_q.enabled) begin
      s_d.count = s_q.count - CNT_STEP;
    end
    // A refresh on a stopped counter is its first enable
    if (bus.refresh) begin
      if (!s_q.enabled) begin
        s_d.enabled = 1'b1;
        s_d.count = reload;
      end else if (refresh_ok) begin
        s_d.count = reload;
      end
    end
    // Time-out response chosen by the option pin
    if (timeout) begin
      s_d.flag_wdt = 1'b1;
      if (bus.stop_mode) begin
        s_d.flag_stop = 1'b1;
        s_d.stop_recover = 1'b1;
      end
      if (irq_mode) begin
        s_d.irq = 1'b1;
        s_d.count = WDTLK_CNT_MAX;
      end else if (!bus.stop_mode) begin
        s_d.sys_reset = 1'b1;
      end else begin
        // Recovery instead of reset: restart from all-ones
        s_d.count = WDTLK_CNT_MAX;
      end
    end
    // Register accesses; key writes store nothing
    if (wr_upper) begin
      s_d.upper = bus.wdata;
    end
    if (wr_middle) begin
      s_d.middle = bus.wdata;
    end
    if (wr_lower) begin
      s_d.lower = bus.wdata;
    end
    if (rd) begin
      if (bus.addr == WDTLK_ADDR_KEY) begin
        s_d.rdata = status_byte(s_q.flag_wdt, s_q.flag_stop);
        // Clear unless a new time-out sets it this cycle
        if (!timeout) begin
          s_d.flag_wdt = 1'b0;
          s_d.flag_stop = 1'b0;
        end
      end else begin
        s_d.rdata = live_byte(s_q.count, bus.addr);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{upper: WDTLK_RST_UPPER, middle: WDTLK_RST_MIDDLE,
               lower: WDTLK_RST_LOWER, count: WDTLK_CNT_MAX,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.rdata = s_q.rdata;
  assign bus.ack = s_q.ack;
  assign bus.irq = s_q.irq;
  assign bus.sys_reset = s_q.sys_reset;
  assign bus.stop_recover = s_q.stop_recover;
endmodule
`default_nettype wire

// ===== wdtlk_core.sv
// Core-side end: AHB-Lite command registers driving the register port
`timescale 1ns/1ps
`default_nettype none
module wdtlk_core
  import wdtlk_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic stop_mode_in,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  wdtlk_if.core port
);
  typedef struct packed {
    logic wpend;
    logic [7:0] waddr;
    logic [31:0] rdata;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic we;
    logic req;
    logic busy;
    logic refresh;
    logic [7:0] last_rd;
    logic stop_mode;
  } wdtlk_core_state_t;
  wdtlk_core_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;
    s_d.refresh = 1'b0;
    s_d.wpend = 1'b0;
    s_d.stop_mode = stop_mode_in;
    if (hsel && hready && htrans[1]) begin
      s_d.wpend = hwrite;
      s_d.waddr = haddr[7:0];
      unique case (haddr[7:0])
        WDTLK_HREG_STATUS: s_d.rdata = {31'h0, s_q.busy};
        WDTLK_HREG_RDATA: s_d.rdata = {24'h0, s_q.last_rd};
        WDTLK_HREG_WDATA: s_d.rdata = {24'h0, s_q.wdata};
        default: s_d.rdata = 32'h0;
      endcase
    end
    if (s_q.wpend) begin
      if (s_q.waddr == WDTLK_HREG_WDATA) begin
        s_d.wdata = hwdata[7:0];
      end else if (s_q.waddr == WDTLK_HREG_CMD && !s_q.busy) begin
        s_d.addr = hwdata[WDTLK_CMD_ADDR_LSB +: 12];
        s_d.we = hwdata[WDTLK_CMD_WRITE_BIT];
        s_d.refresh = hwdata[WDTLK_CMD_REFRESH_BIT];
        if (hwdata[WDTLK_CMD_GO_BIT]) begin
          s_d.req = 1'b1;
          s_d.busy = 1'b1;
        end
      end
    end
    if (port.ack) begin
      s_d.busy = 1'b0;
      if (!s_q.we) begin
        s_d.last_rd = port.rdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign port.req = s_q.req;
  assign port.we = s_q.we;
  assign port.addr = s_q.addr;
  assign port.wdata = s_q.wdata;
  assign port.refresh = s_q.refresh;
  assign port.stop_mode = s_q.stop_mode;
endmodule
`default_nettype wire

// ===== wdtlk_sva.sv
// Interface checks between the core end and the supervision counter
`timescale 1ns/1ps
`default_nettype none
module wdtlk_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic stop_mode,
  input wire logic irq,
  input wire logic sys_reset,
  input wire logic stop_recover
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  chk_ack_after_req: assert property (req |=> ack)
    else $error("ack missing after request");
  chk_ack_has_req: assert property (ack |-> $past(req))
    else $error("ack without request");
  chk_rdata_holds: assert property (
    $changed(rdata) |-> ack || $past(ack))
    else $error("read data moved without a read");
  chk_irq_gap: assert property (irq |=> !irq [*3])
    else $error("interrupt repeated too soon");
  chk_resp_exclusive: assert property (!(irq && sys_reset))
    else $error("interrupt and reset together");
  chk_no_reset_stop: assert property ($past(stop_mode) |-> !sys_reset)
    else $error("system reset while stopped");
  chk_recover_stop: assert property (stop_recover |-> $past(stop_mode))
    else $error("recovery outside stop");
  chk_recover_pulse: assert property (stop_recover |=> !stop_recover)
    else $error("recovery pulse too long");
  chk_reset_pulse: assert property (sys_reset |=> !sys_reset)
    else $error("reset pulse too long");
  cover property (irq);
  cover property (sys_reset);
  cover property (stop_recover && irq);
  cover property (ack && !we);
endmodule
`default_nettype wire

// ===== wdtlk_bench.sv
// Bench: AHB-Lite driven controller facing the supervision counter
`timescale 1ns/1ps
`default_nettype none
module wdtlk_bench
  import wdtlk_pkg::*;
;
  localparam logic [11:0] a_key = WDTLK_ADDR_KEY;
  localparam logic [11:0] a_up = WDTLK_ADDR_UPPER;
  localparam logic [11:0] a_mid = WDTLK_ADDR_MIDDLE;
  localparam logic [11:0] a_low = WDTLK_ADDR_LOWER;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic stop_in = 1'b0;
  logic ao = 1'b0;
  logic resp = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic hreadyout;
  logic hresp;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  always #50 hclk = ~hclk;
  wdtlk_if u_wdtlk_if ();
  wdtlk_core u_wdtlk_core (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .stop_mode_in(stop_in),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .port(u_wdtlk_if.core));
  wdtlk_device u_wdtlk_device (.hclk(hclk), .hresetn(hresetn),
    .always_on_option(ao), .timeout_response_option(resp),
    .bus(u_wdtlk_if.device));
  wdtlk_sva u_wdtlk_sva (.hclk(hclk), .hresetn(hresetn),
    .req(u_wdtlk_if.req), .we(u_wdtlk_if.we), .rdata(u_wdtlk_if.rdata),
    .ack(u_wdtlk_if.ack), .stop_mode(u_wdtlk_if.stop_mode),
    .irq(u_wdtlk_if.irq), .sys_reset(u_wdtlk_if.sys_reset),
    .stop_recover(u_wdtlk_if.stop_recover));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // One access on the register port, waiting out the busy flag
  task op(input logic [11:0] a, input logic [2:0] c, input logic [7:0] d);
    ahb(1'b1, WDTLK_HREG_WDATA, {24'h000000, d});
    ahb(1'b1, WDTLK_HREG_CMD, {12'h000, a, 5'h00, c});
    q = 32'h00000001;
    while (q[0] === 1'b1) ahb(1'b0, WDTLK_HREG_STATUS, 32'h00000000);
    ahb(1'b0, WDTLK_HREG_RDATA, 32'h00000000);
  endtask
  task rd(input string n, input logic [11:0] a, input logic [7:0] m,
          input logic [7:0] e);
    op(a, 3'h1, 8'h00);
    chk(n, {24'h000000, q[7:0] & m}, {24'h000000, e});
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    op(a, 3'h3, d);
  endtask
  task kick;
    op(12'h000, 3'h5, 8'h00);
  endtask
  task wait_ev(input string n, input logic [2:0] m);
    logic [2:0] got;
    got = 3'h0;
    for (int i = 0; i < 1500 && got != m; i++) begin
      @(posedge hclk);
      got = got | {u_wdtlk_if.stop_recover, u_wdtlk_if.sys_reset,
                   u_wdtlk_if.irq};
    end
    chk(n, {29'h00000000, got}, {29'h00000000, m});
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd("idle upper", a_up, 8'hFF, 8'hFF);
    rd("idle status", a_key, 8'h30, 8'h00);
    chk("hresp", {31'h00000000, hresp}, 32'h00000000);
    $display("test idle done");
    wr(a_key, WDTLK_KEY_FIRST);
    wr(a_key, WDTLK_KEY_SECOND);
    wr(a_up, 8'h00);
    wr(a_mid, 8'h01);
    wr(a_low, 8'h80);
    kick;
    rd("live upper", a_up, 8'hFF, 8'h00);
    rd("live middle", a_mid, 8'hFF, 8'h01);
    wait_ev("irq", 3'b001);
    rd("max upper", a_up, 8'hFF, 8'hFF);
    rd("flag set", a_key, 8'h30, 8'h20);
    rd("flag cleared", a_key, 8'h20, 8'h00);
    $display("test interrupt done");
    wr(a_up, 8'h10);
    wr(a_key, WDTLK_KEY_FIRST);
    wr(a_mid, 8'h00);
    wr(a_key, WDTLK_KEY_SECOND);
    wr(a_up, 8'h10);
    wr(a_mid, 8'h10);
    wr(a_low, 8'h10);
    kick;
    rd("kept upper", a_up, 8'hFF, 8'h00);
    rd("kept middle", a_mid, 8'hFF, 8'h01);
    $display("test relock done");
    resp <= 1'b1;
    stop_in <= 1'b1;
    wait_ev("stop reset", 3'b100);
    rd("stop reset flags", a_key, 8'h30, 8'h30);
    resp <= 1'b0;
    kick;
    wait_ev("stop irq", 3'b101);
    rd("stop irq flags", a_key, 8'h30, 8'h30);
    $display("test stop done");
    stop_in <= 1'b0;
    resp <= 1'b1;
    kick;
    wait_ev("reset", 3'b010);
    rd("reset flag", a_key, 8'h20, 8'h20);
    $display("test reset done");
    hresetn <= 1'b0;
    ao <= 1'b1;
    resp <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd("auto upper", a_up, 8'hFF, 8'h00);
    rd("auto middle", a_mid, 8'hFF, 8'h03);
    $display("test always on done");
    wrap_up;
  end
endmodule
`default_nettype wire
